//--- bench/bpfc_peer.sv
// Far-side peer: word source and permit driver
`timescale 1ns/1ps
module bpfc_peer (
    input  wire       core_clk,
    input  wire       port_clk_r,
    input  wire       strobe_out_r,
    input  wire       can_take,
    output wire       permit_in,
    output reg  [7:0] pin_in
);
    reg clk_q_r = 1'b0;
    assign permit_in = can_take;
    // next word after strobed fall, held a full period
    always @(posedge core_clk) begin
        clk_q_r <= port_clk_r;
        if (clk_q_r && !port_clk_r && strobe_out_r)
            pin_in <= pin_in + 8'h01;
    end
    initial pin_in = 8'h10;
endmodule // bpfc_peer

//--- bench/bpfc_port_sva.sv
// Checker for the buffered flow-controlled port
`timescale 1ns/1ps
`include "bpfc_defines.vh"
module bpfc_port_sva (
    // Clock and reset
    input wire       core_clk,
    input wire       rstn,
    // Configuration
    input wire       cfg_load,
    input wire [1:0] cfg_mode,
    input wire [7:0] cfg_init,
    input wire [1:0] cfg_permit_w,
    input wire [1:0] cfg_valid_w,
    input wire [1:0] cfg_space_w,
    input wire [1:0] mode_r,
    input wire       cfg_exc_r,
    // Port pins
    input wire       port_clk_r,
    input wire [7:0] pin_out_r,
    input wire       pin_oe_n_r,
    input wire       permit_in,
    input wire       strobe_out_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Mode decodes and a bad width request
    wire hs  = mode_r == `BPFC_MODE_HSOUT;
    wire sm  = mode_r == `BPFC_MODE_SMIN;
    wire bad = cfg_permit_w != 2'h1 || cfg_valid_w != 2'h1;
    // Settled cycle: same mode, no reload, no port falling edge
    sequence calm(m);
        m && $past(m) && !$past(cfg_load) && !$fell(port_clk_r);
    endsequence
    // Rejected load leaves the port off; only the handshake check also wants pins released
    AST_HS_EXC: assert property (
        cfg_load && cfg_mode == `BPFC_MODE_HSOUT && bad
        |=> cfg_exc_r && mode_r == 2'h0 && pin_oe_n_r)
        else $error("wide line taken");
    AST_SM_EXC: assert property (
        cfg_load && cfg_mode == `BPFC_MODE_SMIN && cfg_space_w != 2'h1
        |=> cfg_exc_r && mode_r == 2'h0) else $error("wide strobe taken");
    AST_INIT: assert property (
        cfg_load && cfg_mode == `BPFC_MODE_HSOUT && !bad
        |=> hs && !pin_oe_n_r && pin_out_r == $past(cfg_init))
        else $error("start value not driven");
    AST_PIN_HOLD: assert property (
        calm(hs) |-> $stable(pin_out_r))
        else $error("pins moved off a falling edge");
    AST_VSTB_EDGE: assert property (
        calm(hs) |-> $stable(strobe_out_r))
        else $error("valid strobe moved off a falling edge");
    AST_NEW_STB: assert property (
        hs && $past(hs) && !$past(cfg_load) && $changed(pin_out_r)
        |-> strobe_out_r) else $error("new word without strobe");
    // Twelve cycles covers sync plus one sample at the bench divider
    AST_PERMIT: assert property (
        (hs && !permit_in)[*8] ##1 (hs && !permit_in)[*4]
        |-> !$rose(strobe_out_r)) else $error("sent without permit");
    AST_SPACE_EDGE: assert property (
        calm(sm) |-> $stable(strobe_out_r))
        else $error("space strobe moved off a falling edge");
    cover property (hs && $rose(strobe_out_r));
    cover property (sm && $fell(strobe_out_r));
    cover property ($rose(cfg_exc_r));
endmodule // bpfc_port_sva

//--- bench/tb_bpfc_port.sv
// Testbench for the buffered flow-controlled port
`timescale 1ns/1ps
`include "bpfc_defines.vh"
module tb_bpfc_port;
    localparam [1:0] hs_m = `BPFC_MODE_HSOUT, sm_m = `BPFC_MODE_SMIN;
    reg        core_clk = 1'b0, rstn = 1'b0, cfg_load = 1'b0;
    reg        tx_valid = 1'b0, rx_ready = 1'b0, can_take = 1'b0;
    reg  [1:0] cfg_mode = 2'h0, cfg_permit_w = 2'h1;
    reg  [1:0] cfg_valid_w = 2'h1, cfg_space_w = 2'h1;
    reg  [7:0] cfg_init = 8'h00, cfg_div = 8'h04, tx_data = 8'h00, exp;
    reg  [3:0] cfg_sample_dly = 4'h0;
    wire [1:0] mode_r;
    wire       cfg_exc_r, tx_ready, rx_valid, port_clk_r, pin_oe_n_r;
    wire       permit_in, strobe_out_r;
    wire [7:0] rx_data, pin_out_r, pin_in;
    integer    fails = 0, samples_checked = 0, i, n;
    // Free-running core clock
    always #12.5 core_clk = ~core_clk;
    bpfc_port u_bpfc_port (.core_clk(core_clk), .rstn(rstn),
        .cfg_load(cfg_load), .cfg_mode(cfg_mode), .cfg_init(cfg_init),
        .cfg_div(cfg_div), .cfg_sample_dly(cfg_sample_dly),
        .cfg_permit_w(cfg_permit_w), .cfg_valid_w(cfg_valid_w),
        .cfg_space_w(cfg_space_w), .mode_r(mode_r), .cfg_exc_r(cfg_exc_r),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .port_clk_r(port_clk_r), .pin_out_r(pin_out_r),
        .pin_oe_n_r(pin_oe_n_r), .pin_in(pin_in), .permit_in(permit_in),
        .strobe_out_r(strobe_out_r));
    bpfc_peer u_bpfc_peer (.core_clk(core_clk), .port_clk_r(port_clk_r),
        .strobe_out_r(strobe_out_r), .can_take(can_take),
        .permit_in(permit_in), .pin_in(pin_in));
    task check(input [7:0] seen, input [7:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("[FAIL] %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Bounded wait: 0 strobe, 1 rx_valid, 2 tx_ready, 3 word on pins
    task wait_on(input integer sel, input v);
        begin
            n = 0;
            do begin
                @(posedge core_clk);
                n = n + 1;
            end while ((sel == 0 ? strobe_out_r : sel == 1 ? rx_valid :
                sel == 2 ? tx_ready : pin_out_r == tx_data) !== v && n < 400);
            if (n == 400) begin
                fails = fails + 1;
                $display("[FAIL] %0t wait ran out", $time);
                complete_run;
            end
        end
    endtask
    task load(input [1:0] m, input [1:0] pw, vw, sw, input [7:0] ini);
        begin
            @(posedge core_clk);
            {cfg_load, cfg_mode, cfg_permit_w} <= {1'b1, m, pw};
            {cfg_valid_w, cfg_space_w, cfg_init} <= {vw, sw, ini};
            @(posedge core_clk);
            cfg_load <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task t_bad;
        begin
            // Rejected loads: port stays off, pins released after the two handshake loads
            load(hs_m, 2'h2, 2'h1, 2'h1, 8'h00);
            check({mode_r, cfg_exc_r}, 8'h01);
            check({port_clk_r, pin_oe_n_r}, 8'h01);
            load(hs_m, 2'h1, 2'h3, 2'h1, 8'h00);
            check({mode_r, cfg_exc_r}, 8'h01);
            check({port_clk_r, pin_oe_n_r}, 8'h01);
            load(sm_m, 2'h1, 2'h1, 2'h0, 8'h00);
            check({mode_r, cfg_exc_r}, 8'h01);
        end
    endtask
    task t_hs;
        begin
            load(hs_m, 2'h1, 2'h1, 2'h1, 8'ha5);
            check({mode_r, pin_oe_n_r}, 8'h02);
            {tx_valid, tx_data} <= {1'b1, 8'h3c};
            wait_on(2, 1'b1);
            tx_valid <= 1'b0;
            // Permit held low: word must stay back
            repeat (40) @(posedge core_clk);
            check(pin_out_r, 8'ha5);
            check(strobe_out_r, 8'h00);
            can_take <= 1'b1;
            wait_on(0, 1'b1);
            check(pin_out_r, 8'h3c);
            {tx_valid, tx_data} <= {1'b1, 8'hc3};
            wait_on(2, 1'b1);
            tx_valid <= 1'b0;
            wait_on(3, 1'b1);
            check(strobe_out_r, 8'h01);
            wait_on(0, 1'b0);
            check(pin_out_r, 8'hc3);
            can_take <= 1'b0;
        end
    endtask
    task t_sm;
        begin
            cfg_sample_dly <= 4'h1;
            exp = u_bpfc_peer.pin_in + 8'h01;
            load(sm_m, 2'h1, 2'h1, 2'h1, 8'h00);
            check({mode_r, cfg_exc_r}, 8'h04);
            wait_on(0, 1'b1);
            wait_on(0, 1'b0);
            check(rx_valid, 8'h01);
            // Six pops: buffer drains and refills after the stall
            for (i = 0; i < 6; i = i + 1) begin
                wait_on(1, 1'b1);
                check(rx_data, exp);
                exp = exp + 8'h01;
                rx_ready <= 1'b1;
                @(posedge core_clk);
                rx_ready <= 1'b0;
                repeat (3) @(posedge core_clk);
            end
        end
    endtask
    // Reset, then scenarios in turn
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        t_bad;
        t_hs;
        t_sm;
        complete_run;
    end
endmodule // tb_bpfc_port
bind bpfc_port bpfc_port_sva u_bpfc_port_sva (.core_clk(core_clk),
    .rstn(rstn), .cfg_load(cfg_load), .port_clk_r(port_clk_r),
    .permit_in(permit_in), .strobe_out_r(strobe_out_r),
    .cfg_exc_r(cfg_exc_r), .pin_oe_n_r(pin_oe_n_r), .cfg_mode(cfg_mode),
    .cfg_permit_w(cfg_permit_w), .cfg_valid_w(cfg_valid_w),
    .cfg_space_w(cfg_space_w), .mode_r(mode_r), .cfg_init(cfg_init),
    .pin_out_r(pin_out_r));

//--- hdl/bpfc_defines.vh
// Constants for the buffered flow-controlled port
// How it works
// - Handshake output with flow lines wider than one bit raises an exception.
// - Strobed-master input with strobe wider than one bit raises an exception.
// - Handshake output holds the starting value until the first word is sent.
// - Flow-permit input is captured on every sampling edge in handshake output mode.
// - New data goes out only at falling edges after a high permit.
// - Valid strobe is high on falling edges that drive new data.
// - Sampling edge defaults to rising; a sample delay can move it.
// - Space strobe asserts at falling edges while receive buffer not full.
// - Input pins are captured on the sampling edge after space strobe.
`ifndef BPFC_DEFINES_VH
`define BPFC_DEFINES_VH
`define BPFC_DATA_W      8
`define BPFC_DIV_W       8
`define BPFC_DLY_W       4
`define BPFC_DEPTH_W     2
`define BPFC_DEPTH       4
`define BPFC_MODE_OFF    2'h0
`define BPFC_MODE_HSOUT  2'h1
`define BPFC_MODE_SMIN   2'h2
`define BPFC_DIV_RST     8'h02
`define BPFC_DLY_RST     4'h0
`endif

//--- hdl/bpfc_port.v
// Buffered port with handshake output and strobed-master input modes
`timescale 1ns/1ps
`include "bpfc_defines.vh"
module bpfc_port (
    // Clock and reset
    input  wire                   core_clk,
    input  wire                   rstn,
    // Configuration
    input  wire                   cfg_load,
    input  wire [1:0]             cfg_mode,
    input  wire [7:0]             cfg_init,
    input  wire [7:0]             cfg_div,
    input  wire [3:0]             cfg_sample_dly,
    input  wire [1:0]             cfg_permit_w,
    input  wire [1:0]             cfg_valid_w,
    input  wire [1:0]             cfg_space_w,
    output reg  [1:0]             mode_r,
    output reg                    cfg_exc_r,
    // Software output words
    input  wire                   tx_valid,
    input  wire [7:0]             tx_data,
    output wire                   tx_ready,
    // Software input words
    output wire                   rx_valid,
    output wire [7:0]             rx_data,
    input  wire                   rx_ready,
    // Port pins
    output reg                    port_clk_r,
    output reg  [7:0]             pin_out_r,
    output reg                    pin_oe_n_r,
    input  wire [7:0]             pin_in,
    input  wire                   permit_in,
    output reg                    strobe_out_r
);
    reg [7:0] div_r;
    reg [7:0] div_val_r;
    reg [3:0] dly_val_r;
    reg [3:0] dly_r;
    reg       dly_run_r;
    reg [7:0] pin_s1_r;
    reg [7:0] pin_s2_r;
    reg       permit_s1_r;
    reg       permit_s2_r;
    reg       permit_cap_r;
    reg [7:0] tx_hold_r;
    reg       tx_full_r;
    reg [2:0] rx_cnt_r;
    reg [1:0] wr_ptr_r;
    reg [1:0] rd_ptr_r;
    reg       rd_pend_r;
    reg       out_vld_r;
    wire      rise_en;
    wire      fall_en;
    wire      samp_en;
    wire      rx_full;
    wire      rx_push;
    wire      rx_pop;
    wire      rd_fire;
    wire      send_now;
    wire      hs_cfg_ok;

    // Port clock edges derived from core clock by a divider
    assign rise_en = (div_r == div_val_r) && !port_clk_r;
    assign fall_en = (div_r == div_val_r) && port_clk_r;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_r      <= 8'h00;
            port_clk_r <= 1'b0;
        end else if (mode_r == `BPFC_MODE_OFF) begin
            div_r      <= 8'h00;
            port_clk_r <= 1'b0;
        end else if (div_r == div_val_r) begin
            div_r      <= 8'h00;
            port_clk_r <= ~port_clk_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Sampling point: rise edge, or a delay after it in core cycles
    // sampling edge select
    assign samp_en = (dly_val_r == 4'h0) ? rise_en
                   : (dly_run_r && dly_r == 4'h1);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dly_r     <= 4'h0;
            dly_run_r <= 1'b0;
        end else if (rise_en && dly_val_r != 4'h0) begin
            dly_r     <= dly_val_r;
            dly_run_r <= 1'b1;
        end else if (dly_run_r) begin
            dly_r     <= dly_r - 4'h1;
            dly_run_r <= (dly_r != 4'h1);
        end
    end

    // Configuration load with width checks; rejected modes fall to off
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r    <= `BPFC_MODE_OFF;
            cfg_exc_r <= 1'b0;
            div_val_r <= `BPFC_DIV_RST;
            dly_val_r <= `BPFC_DLY_RST;
        end else if (cfg_load) begin
            div_val_r <= (cfg_div == 8'h00) ? 8'h01 : cfg_div;
            dly_val_r <= cfg_sample_dly;
            cfg_exc_r <= 1'b0;
            mode_r    <= cfg_mode;
            if (cfg_mode == `BPFC_MODE_HSOUT &&
                (cfg_permit_w != 2'h1 || cfg_valid_w != 2'h1)) begin
                cfg_exc_r <= 1'b1;
                mode_r    <= `BPFC_MODE_OFF;
            end
            if (cfg_mode == `BPFC_MODE_SMIN && cfg_space_w != 2'h1) begin
                cfg_exc_r <= 1'b1;
                mode_r    <= `BPFC_MODE_OFF;
            end
            if (cfg_mode == 2'h3) begin
                cfg_exc_r <= 1'b1;
                mode_r    <= `BPFC_MODE_OFF;
            end
        end
    end

    // Pin inputs cross in through two flops before use
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r    <= 8'h00;
            pin_s2_r    <= 8'h00;
            permit_s1_r <= 1'b0;
            permit_s2_r <= 1'b0;
        end else begin
            pin_s1_r    <= pin_in;
            pin_s2_r    <= pin_s1_r;
            permit_s1_r <= permit_in;
            permit_s2_r <= permit_s1_r;
        end
    end

    // One-word transmit holding buffer
    assign tx_ready = (mode_r == `BPFC_MODE_HSOUT) && !tx_full_r;
    // send only after high captured permit
    assign send_now = fall_en && tx_full_r && permit_cap_r;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_hold_r <= 8'h00;
            tx_full_r <= 1'b0;
        end else if (cfg_load) begin
            tx_full_r <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            tx_hold_r <= tx_data;
            tx_full_r <= 1'b1;
        end else if (send_now) begin
            tx_full_r <= 1'b0;
        end
    end

    // Permit capture on each sampling edge in handshake output mode
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            permit_cap_r <= 1'b0;
        end else if (cfg_load) begin
            permit_cap_r <= 1'b0;
        end else if (samp_en && mode_r == `BPFC_MODE_HSOUT) begin
            permit_cap_r <= permit_s2_r;
        end
    end

    // Pins driven only for an accepted handshake load, so a rejected
    // configuration never drives the bus for a stray cycle
    assign hs_cfg_ok = (cfg_mode == `BPFC_MODE_HSOUT) &&
                       (cfg_permit_w == 2'h1) && (cfg_valid_w == 2'h1);

    // Output pins and strobe: set on a load, released when off, otherwise updated at falling edges
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_out_r    <= 8'h00;
            pin_oe_n_r   <= 1'b1;
            strobe_out_r <= 1'b0;
        end else if (cfg_load) begin
            pin_out_r    <= cfg_init;
            pin_oe_n_r   <= !hs_cfg_ok;
            strobe_out_r <= 1'b0;
        end else if (mode_r == `BPFC_MODE_OFF) begin
            pin_oe_n_r   <= 1'b1;
            strobe_out_r <= 1'b0;
        end else if (fall_en) begin
            if (mode_r == `BPFC_MODE_HSOUT) begin
                strobe_out_r <= send_now;
                if (send_now) begin
                    pin_out_r <= tx_hold_r;
                end
            end else begin
                strobe_out_r <= !rx_full;
            end
        end
    end

    // Receive buffer bookkeeping; the strobe reserves room one word ahead
    assign rx_full = (rx_cnt_r >= 3'h4) ||
                     (rx_cnt_r == 3'h3 && strobe_out_r);
    assign rx_push = samp_en && strobe_out_r &&
                     (mode_r == `BPFC_MODE_SMIN) && (rx_cnt_r != 3'h4);
    assign rd_fire = (rx_cnt_r != 3'h0) && (!out_vld_r || rx_pop) &&
                     !rd_pend_r;
    assign rx_pop  = out_vld_r && rx_ready;
    assign rx_valid = out_vld_r;

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_cnt_r  <= 3'h0;
            wr_ptr_r  <= 2'h0;
            rd_ptr_r  <= 2'h0;
            rd_pend_r <= 1'b0;
            out_vld_r <= 1'b0;
        end else begin
            rx_cnt_r <= rx_cnt_r + {2'h0, rx_push} - {2'h0, rd_fire};
            if (rx_push) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (rd_fire) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            rd_pend_r <= rd_fire;
            if (rd_pend_r) begin
                out_vld_r <= 1'b1;
            end else if (rx_pop) begin
                out_vld_r <= 1'b0;
            end
        end
    end

    // Receive storage
    bpfc_rx_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (rx_push),
        .wr_addr  (wr_ptr_r),
        .wr_data  (pin_s2_r),
        .rd_en    (rd_fire),
        .rd_addr  (rd_ptr_r),
        .rd_data  (rx_data)
    );
endmodule // bpfc_port

//--- hdl/bpfc_rx_mem.v
// Small receive buffer memory with registered read data
`timescale 1ns/1ps
module bpfc_rx_mem (
    // Clock
    input  wire                   core_clk,
    // Write side
    input  wire                   wr_en,
    input  wire [1:0]             wr_addr,
    input  wire [7:0]             wr_data,
    // Read side
    input  wire                   rd_en,
    input  wire [1:0]             rd_addr,
    output reg  [7:0]             rd_data
);
    reg [7:0] mem [0:3];

    // Storage and registered read; no reset needed for data
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // bpfc_rx_mem
